// [src/io_claim_pkg.sv]
// Register map, field layout and decode windows for the I/O claim decoder
package io_claim_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] OFS_SLOT_NINE   = 8'h60;
	localparam logic [7:0] OFS_DECODE_CTRL = 8'h64;
	localparam logic [7:0] OFS_MONITOR     = 8'h80;
	localparam logic [7:0] OFS_STATUS      = 8'h84;
	localparam int         OFS_WIDTH       = 8;

	// Reset values
	localparam logic [31:0] RST_SLOT_NINE   = 32'h0000_0000;
	localparam logic [31:0] RST_DECODE_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_MONITOR     = 32'h0000_0000;

	// Writable bits; everything else reads as zero
	localparam logic [31:0] WMASK_SLOT_NINE   = 32'h000F_FFFF;
	localparam logic [31:0] WMASK_DECODE_CTRL = 32'hFFEF_FFFF;
	localparam logic [31:0] WMASK_MONITOR     = 32'h0000_0003;

	// Decode control fields
	localparam int SERIAL_B_CLAIM_BIT   = 31;
	localparam int SERIAL_B_SEL_MSB     = 30;
	localparam int SERIAL_B_SEL_LSB     = 28;
	localparam int SERIAL_A_CLAIM_BIT   = 27;
	localparam int SERIAL_A_SEL_MSB     = 26;
	localparam int SERIAL_A_SEL_LSB     = 24;
	localparam int TEN_CHIP_SELECT_BIT  = 23;
	localparam int TEN_CLAIM_BIT        = 22;
	localparam int TEN_MONITOR_BIT      = 21;
	localparam int MASK_MSB             = 19;
	localparam int MASK_LSB             = 16;
	localparam int BASE_MSB             = 15;
	localparam int BASE_LSB             = 0;

	// Monitor register fields
	localparam int SERIAL_A_MONITOR_BIT = 0;
	localparam int SERIAL_B_MONITOR_BIT = 1;

	// Serial windows are eight bytes: low three address bits ignored
	localparam int SERIAL_WINDOW_LSB = 3;
	localparam logic [15:0] SERIAL_WIN_0 = 16'h03F8;
	localparam logic [15:0] SERIAL_WIN_1 = 16'h02F8;
	localparam logic [15:0] SERIAL_WIN_2 = 16'h0220;
	localparam logic [15:0] SERIAL_WIN_3 = 16'h0228;
	localparam logic [15:0] SERIAL_WIN_4 = 16'h0238;
	localparam logic [15:0] SERIAL_WIN_5 = 16'h02E8;
	localparam logic [15:0] SERIAL_WIN_6 = 16'h0338;
	localparam logic [15:0] SERIAL_WIN_7 = 16'h03E8;

	typedef struct packed {
		logic        io_cycle;
		logic [15:0] addr;
	} decode_req_type;

	typedef struct packed {
		logic claim;
		logic chip_select_n;
		logic slot_nine_hit;
		logic slot_ten_hit;
		logic serial_a_hit;
		logic serial_b_hit;
	} decode_res_type;

	localparam decode_res_type RST_RESULT = '{
		claim: 1'b0, chip_select_n: 1'b1, slot_nine_hit: 1'b0,
		slot_ten_hit: 1'b0, serial_a_hit: 1'b0, serial_b_hit: 1'b0};

endpackage : io_claim_pkg

// [src/io_range_claim_decode.sv]
// Host I/O cycle claim decoder with Wishbone register slave
//
// Contract
// - Slot nine holds a 16-bit base compared against address bits 15..0.
// - Slot nine 4-bit mask in bits 19..16 drops address bits 3..0.
// - Bit 31 with serial B monitor enable claims serial B window.
// - Serial B codes 0..3: 3F8h, 2F8h, 220h, 228h windows.
// - Serial B codes 4..7: 238h, 2E8h, 338h, 3E8h; eight bytes each.
// - Bit 27 with serial A monitor enable claims serial A window.
// - Serial A selector bits 26..24 decode like the serial B selector.
// - Bit 23 with slot ten claim enable drives chip select low on hit.
// - Bit 22 with slot ten monitor enable claims slot ten window.
// - Bit 21 enables slot ten decode; functions need their own enable too.
// - Slot ten mask bits 19..16 drop address bits 3..0 from compare.
// - Non-contiguous masks accepted as is, giving split windows.
// - Slot ten 16-bit base in bits 15..0 compared to address 15..0.
`timescale 1ns/1ps

module io_range_claim_decode #(
	parameter int WB_ADR_WIDTH = 8
) (
	// Clock and reset
	input  wire logic                           REF_CLK_I,
	input  wire logic                           SYS_RST_I,
	// Wishbone classic slave
	input  wire logic                           WB_CYC_I,
	input  wire logic                           WB_STB_I,
	input  wire logic                           WB_WE_I,
	input  wire logic [WB_ADR_WIDTH-1:0]        WB_ADR_I,
	input  wire logic [3:0]                     WB_SEL_I,
	input  wire logic [31:0]                    WB_DAT_I,
	output      logic [31:0]                    WB_DAT_O,
	output      logic                           WB_ACK_O,
	// Host I/O cycle to decode
	input  wire io_claim_pkg::decode_req_type   DECODE_REQ_I,
	// Decode results, one cycle after the request
	output      logic                           EXTENDED_IO_CLAIM_O,
	output      logic                           PERIPHERAL_CHIP_SELECT_1_N_O,
	output      logic                           SLOT_NINE_HIT_O
);

	if (WB_ADR_WIDTH < io_claim_pkg::OFS_WIDTH) begin : g_adr_check
		$error("WB_ADR_WIDTH too narrow for the register map");
	end

	// Decode helpers
	function automatic logic generic_hit(
		input logic [15:0] addr,
		input logic [15:0] base,
		input logic [3:0]  mask
	);
		logic [15:0] care;
		care = ~{12'h000, mask};
		// Mask taken verbatim so split patterns give split windows
		return ((addr ^ base) & care) == 16'h0000;
	endfunction : generic_hit

	function automatic logic [15:0] serial_window(input logic [2:0] code);
		logic [15:0] win;
		case (code)
			3'h0:    win = io_claim_pkg::SERIAL_WIN_0;
			3'h1:    win = io_claim_pkg::SERIAL_WIN_1;
			3'h2:    win = io_claim_pkg::SERIAL_WIN_2;
			3'h3:    win = io_claim_pkg::SERIAL_WIN_3;
			3'h4:    win = io_claim_pkg::SERIAL_WIN_4;
			3'h5:    win = io_claim_pkg::SERIAL_WIN_5;
			3'h6:    win = io_claim_pkg::SERIAL_WIN_6;
			default: win = io_claim_pkg::SERIAL_WIN_7;
		endcase
		return win;
	endfunction : serial_window

	function automatic logic [31:0] merge_write(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  sel,
		input logic [31:0] wmask
	);
		logic [31:0] lanes;
		lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return ((old_val & ~lanes) | (new_val & lanes)) & wmask;
	endfunction : merge_write

	// Registers
	logic [31:0]                 slot_nine_reg;
	logic [31:0]                 slot_nine_next;
	logic [31:0]                 ctrl_reg;
	logic [31:0]                 ctrl_next;
	logic [31:0]                 monitor_reg;
	logic [31:0]                 monitor_next;
	logic                        ack_reg;
	logic                        ack_next;
	logic [31:0]                 rdata_reg;
	logic [31:0]                 rdata_next;
	io_claim_pkg::decode_res_type result_reg;
	io_claim_pkg::decode_res_type result_next;

	// Bus decode
	wire logic [7:0] bus_ofs;
	wire logic       bus_req;
	wire logic       bus_wr;
	wire logic       sel_nine;
	wire logic       sel_ctrl;
	wire logic       sel_mon;
	wire logic       sel_stat;
	wire logic [31:0] status_word;
	wire logic [31:0] read_word;

	assign bus_ofs  = WB_ADR_I[io_claim_pkg::OFS_WIDTH-1:0];
	// Ack drops in the cycle after it was given
	assign bus_req  = WB_CYC_I && WB_STB_I && !ack_reg;
	assign bus_wr   = bus_req && WB_WE_I;
	assign sel_nine = bus_ofs == io_claim_pkg::OFS_SLOT_NINE;
	assign sel_ctrl = bus_ofs == io_claim_pkg::OFS_DECODE_CTRL;
	assign sel_mon  = bus_ofs == io_claim_pkg::OFS_MONITOR;
	assign sel_stat = bus_ofs == io_claim_pkg::OFS_STATUS;

	assign status_word = {26'h0, result_reg};
	// Unmapped offsets read zero and still get an ack
	assign read_word = sel_nine ? slot_nine_reg :
	                   sel_ctrl ? ctrl_reg :
	                   sel_mon  ? monitor_reg :
	                   sel_stat ? status_word : 32'h0000_0000;

	assign slot_nine_next = (bus_wr && sel_nine) ?
		merge_write(slot_nine_reg, WB_DAT_I, WB_SEL_I,
		            io_claim_pkg::WMASK_SLOT_NINE) : slot_nine_reg;
	assign ctrl_next = (bus_wr && sel_ctrl) ?
		merge_write(ctrl_reg, WB_DAT_I, WB_SEL_I,
		            io_claim_pkg::WMASK_DECODE_CTRL) : ctrl_reg;
	assign monitor_next = (bus_wr && sel_mon) ?
		merge_write(monitor_reg, WB_DAT_I, WB_SEL_I,
		            io_claim_pkg::WMASK_MONITOR) : monitor_reg;
	assign ack_next   = bus_req;
	assign rdata_next = bus_req ? read_word : 32'h0000_0000;

	// Field views
	wire logic [15:0] nine_base;
	wire logic [3:0]  nine_mask;
	wire logic [15:0] ten_base;
	wire logic [3:0]  ten_mask;
	wire logic [2:0]  serial_a_range_select;
	wire logic [2:0]  serial_b_range_select;
	wire logic        serial_a_claim_enable;
	wire logic        serial_b_claim_enable;
	wire logic        serial_a_monitor_enable;
	wire logic        serial_b_monitor_enable;
	wire logic        slot_ten_chip_select_enable;
	wire logic        slot_ten_claim_enable;
	wire logic        slot_ten_monitor_enable;

	assign nine_base = slot_nine_reg[io_claim_pkg::BASE_MSB:
	                                 io_claim_pkg::BASE_LSB];
	assign nine_mask = slot_nine_reg[io_claim_pkg::MASK_MSB:
	                                 io_claim_pkg::MASK_LSB];
	assign ten_base  = ctrl_reg[io_claim_pkg::BASE_MSB:
	                            io_claim_pkg::BASE_LSB];
	assign ten_mask  = ctrl_reg[io_claim_pkg::MASK_MSB:
	                            io_claim_pkg::MASK_LSB];
	assign serial_a_range_select = ctrl_reg[io_claim_pkg::SERIAL_A_SEL_MSB:
	                                        io_claim_pkg::SERIAL_A_SEL_LSB];
	assign serial_b_range_select = ctrl_reg[io_claim_pkg::SERIAL_B_SEL_MSB:
	                                        io_claim_pkg::SERIAL_B_SEL_LSB];
	assign serial_a_claim_enable = ctrl_reg[io_claim_pkg::SERIAL_A_CLAIM_BIT];
	assign serial_b_claim_enable = ctrl_reg[io_claim_pkg::SERIAL_B_CLAIM_BIT];
	assign serial_a_monitor_enable =
		monitor_reg[io_claim_pkg::SERIAL_A_MONITOR_BIT];
	assign serial_b_monitor_enable =
		monitor_reg[io_claim_pkg::SERIAL_B_MONITOR_BIT];
	assign slot_ten_chip_select_enable =
		ctrl_reg[io_claim_pkg::TEN_CHIP_SELECT_BIT];
	assign slot_ten_claim_enable   = ctrl_reg[io_claim_pkg::TEN_CLAIM_BIT];
	assign slot_ten_monitor_enable = ctrl_reg[io_claim_pkg::TEN_MONITOR_BIT];

	// Window decode
	wire logic        io_cyc;
	wire logic [15:0] io_addr;
	wire logic [15:0] win_a;
	wire logic [15:0] win_b;
	wire logic        hit_nine;
	wire logic        hit_ten;
	wire logic        hit_a;
	wire logic        hit_b;
	wire logic        claim_a;
	wire logic        claim_b;
	wire logic        claim_ten;
	wire logic        select_ten;

	assign io_cyc  = DECODE_REQ_I.io_cycle;
	assign io_addr = DECODE_REQ_I.addr;
	assign win_b   = serial_window(serial_b_range_select);
	assign win_a   = serial_window(serial_a_range_select);
	assign hit_b   = io_cyc && io_addr[15:io_claim_pkg::SERIAL_WINDOW_LSB] ==
	                 win_b[15:io_claim_pkg::SERIAL_WINDOW_LSB];
	assign hit_a   = io_cyc && io_addr[15:io_claim_pkg::SERIAL_WINDOW_LSB] ==
	                 win_a[15:io_claim_pkg::SERIAL_WINDOW_LSB];
	assign hit_nine = io_cyc && generic_hit(io_addr, nine_base, nine_mask);
	assign hit_ten  = io_cyc && slot_ten_monitor_enable &&
	                  generic_hit(io_addr, ten_base, ten_mask);

	assign claim_b = hit_b && serial_b_claim_enable &&
	                 serial_b_monitor_enable;
	assign claim_a = hit_a && serial_a_claim_enable &&
	                 serial_a_monitor_enable;
	assign claim_ten  = hit_ten && slot_ten_claim_enable;
	assign select_ten = claim_ten && slot_ten_chip_select_enable;

	always_comb begin
		result_next               = io_claim_pkg::RST_RESULT;
		result_next.claim         = claim_a || claim_b || claim_ten;
		result_next.chip_select_n = !select_ten;
		result_next.slot_nine_hit = hit_nine;
		result_next.slot_ten_hit  = hit_ten;
		result_next.serial_a_hit  = hit_a;
		result_next.serial_b_hit  = hit_b;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			slot_nine_reg <= io_claim_pkg::RST_SLOT_NINE;
			ctrl_reg      <= io_claim_pkg::RST_DECODE_CTRL;
			monitor_reg   <= io_claim_pkg::RST_MONITOR;
			ack_reg       <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			result_reg    <= io_claim_pkg::RST_RESULT;
		end else begin
			slot_nine_reg <= slot_nine_next;
			ctrl_reg      <= ctrl_next;
			monitor_reg   <= monitor_next;
			ack_reg       <= ack_next;
			rdata_reg     <= rdata_next;
			result_reg    <= result_next;
		end
	end

	assign WB_ACK_O                     = ack_reg;
	assign WB_DAT_O                     = rdata_reg;
	assign EXTENDED_IO_CLAIM_O          = result_reg.claim;
	assign PERIPHERAL_CHIP_SELECT_1_N_O = result_reg.chip_select_n;
	assign SLOT_NINE_HIT_O              = result_reg.slot_nine_hit;

	// Checks
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	property p_nine_window;
		io_cyc && nine_mask == 4'h0 && io_addr == nine_base
		|=> SLOT_NINE_HIT_O;
	endproperty
	a_nine_window: assert property (p_nine_window)
		else $error("Slot nine exact base did not hit");

	property p_nine_mask;
		io_cyc && nine_mask == 4'hF && io_addr[15:4] == nine_base[15:4]
		|=> SLOT_NINE_HIT_O;
	endproperty
	a_nine_mask: assert property (p_nine_mask)
		else $error("Slot nine full mask did not cover sixteen bytes");

	property p_serial_b_off;
		!serial_b_claim_enable && !(serial_a_claim_enable &&
		serial_a_monitor_enable) && !slot_ten_claim_enable
		|=> !EXTENDED_IO_CLAIM_O;
	endproperty
	a_serial_b_off: assert property (p_serial_b_off)
		else $error("Claim with every claim enable off");

	property p_serial_b_low;
		io_cyc && serial_b_claim_enable && serial_b_monitor_enable &&
		serial_b_range_select == 3'h1 && io_addr == 16'h02FF
		|=> EXTENDED_IO_CLAIM_O;
	endproperty
	a_serial_b_low: assert property (p_serial_b_low)
		else $error("Serial B code 1 did not claim 2FFh");

	property p_serial_b_high;
		io_cyc && serial_b_claim_enable && serial_b_monitor_enable &&
		serial_b_range_select == 3'h7 && io_addr == 16'h03E8
		|=> EXTENDED_IO_CLAIM_O ##1 1'b1;
	endproperty
	a_serial_b_high: assert property (p_serial_b_high)
		else $error("Serial B code 7 did not claim 3E8h");

	property p_serial_a_need_mon;
		!serial_a_monitor_enable && !serial_b_claim_enable &&
		!slot_ten_claim_enable |=> !EXTENDED_IO_CLAIM_O;
	endproperty
	a_serial_a_need_mon: assert property (p_serial_a_need_mon)
		else $error("Serial A claimed without monitor enable");

	property p_serial_a_map;
		io_cyc && serial_a_claim_enable && serial_a_monitor_enable &&
		serial_a_range_select == 3'h2 && io_addr == 16'h0224
		|=> EXTENDED_IO_CLAIM_O;
	endproperty
	a_serial_a_map: assert property (p_serial_a_map)
		else $error("Serial A code 2 did not claim 224h");

	property p_cs_cause;
		!PERIPHERAL_CHIP_SELECT_1_N_O |->
		$past(slot_ten_chip_select_enable) && $past(slot_ten_claim_enable)
		&& $past(hit_ten) && EXTENDED_IO_CLAIM_O;
	endproperty
	a_cs_cause: assert property (p_cs_cause)
		else $error("Chip select low without enabled slot ten hit");

	property p_ten_claim;
		io_cyc && slot_ten_claim_enable && slot_ten_monitor_enable &&
		io_addr == ten_base |=> EXTENDED_IO_CLAIM_O;
	endproperty
	a_ten_claim: assert property (p_ten_claim)
		else $error("Slot ten base not claimed");

	property p_ten_decode_off;
		!slot_ten_monitor_enable |=> PERIPHERAL_CHIP_SELECT_1_N_O;
	endproperty
	a_ten_decode_off: assert property (p_ten_decode_off)
		else $error("Chip select with slot ten decode off");

	property p_ten_split;
		io_cyc && slot_ten_claim_enable && slot_ten_monitor_enable &&
		slot_ten_chip_select_enable && ten_mask == 4'h9 &&
		io_addr == (ten_base ^ 16'h0009) |=> !PERIPHERAL_CHIP_SELECT_1_N_O;
	endproperty
	a_ten_split: assert property (p_ten_split)
		else $error("Split mask 1001 window missed");

	property p_ten_base_bit;
		io_cyc && slot_ten_claim_enable && slot_ten_monitor_enable &&
		slot_ten_chip_select_enable && io_addr == (ten_base ^ 16'h0010)
		|=> PERIPHERAL_CHIP_SELECT_1_N_O;
	endproperty
	a_ten_base_bit: assert property (p_ten_base_bit)
		else $error("Slot ten hit with address bit 4 off base");

	property p_io_only;
		!io_cyc |=> !EXTENDED_IO_CLAIM_O && PERIPHERAL_CHIP_SELECT_1_N_O
		&& !SLOT_NINE_HIT_O;
	endproperty
	a_io_only: assert property (p_io_only)
		else $error("Decode result on a non I/O cycle");

	property p_ack_one;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("Wishbone ack not a single cycle after request");

endmodule : io_range_claim_decode

// [test/host_io_model.sv]
// Host side model issuing single I/O cycles into the claim decoder
`timescale 1ns/1ps

module host_io_model (
	// Clock
	input  wire logic                         clk_i,
	// Request toward the decoder
	output      io_claim_pkg::decode_req_type req_o
);
	initial begin
		req_o = '0;
	end

	// One cycle per request; idle flips the address so a stale one never
	// looks like a held request
	task automatic issue(input logic io, input logic [15:0] addr);
		@(posedge clk_i);
		req_o <= '{io_cycle: io, addr: addr};
		@(posedge clk_i);
		req_o <= '{io_cycle: 1'b0, addr: ~addr};
	endtask : issue

	// Request that stands until the next call, for status readback
	task automatic hold(input logic io, input logic [15:0] addr);
		@(posedge clk_i);
		req_o <= '{io_cycle: io, addr: addr};
	endtask : hold
endmodule : host_io_model

// [test/io_range_claim_decode_test.sv]
// Self-checking bench for the I/O claim decoder
`timescale 1ns/1ps

module io_range_claim_decode_test;
	localparam logic [15:0] WIN [8] = '{16'h03F8, 16'h02F8, 16'h0220,
		16'h0228, 16'h0238, 16'h02E8, 16'h0338, 16'h03E8};

	logic                         clk;
	logic                         rst;
	logic                         cyc;
	logic                         stb;
	logic                         we;
	logic [7:0]                   adr;
	logic [3:0]                   sel;
	logic [31:0]                  dat_w;
	logic [31:0]                  dat_r;
	logic                         ack;
	io_claim_pkg::decode_req_type req;
	logic                         claim;
	logic                         cs_n;
	logic                         nine;
	int                           n_mismatch = 0;
	int                           n_checks = 0;

	host_io_model i_host (.clk_i(clk), .req_o(req));

	io_range_claim_decode i_dut (
		.REF_CLK_I(clk), .SYS_RST_I(rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
		.DECODE_REQ_I(req), .EXTENDED_IO_CLAIM_O(claim),
		.PERIPHERAL_CHIP_SELECT_1_N_O(cs_n), .SLOT_NINE_HIT_O(nine));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Classic cycle held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		check("wb_ack", {31'h0, ack}, 32'h1);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, 4'hF, d, q);
	endtask : wr

	task automatic rd(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 4'hF, 32'h0, q);
		check(what, q, exp);
	endtask : rd

	// Outputs are registered: look one edge after the request is taken
	task automatic probe(input logic io, input logic [15:0] a,
		input logic c, input logic s, input logic n9);
		i_host.issue(io, a);
		#1;
		check("decode", {29'h0, claim, cs_n, nine}, {29'h0, c, s, n9});
	endtask : probe

	task automatic regs_test;
		logic [31:0] q;
		probe(1'b1, 16'h03F8, 1'b0, 1'b1, 1'b0);
		rd("slot_nine_reg", io_claim_pkg::OFS_SLOT_NINE, 32'h0);
		rd("ctrl_reg", io_claim_pkg::OFS_DECODE_CTRL, 32'h0);
		rd("monitor_reg", io_claim_pkg::OFS_MONITOR, 32'h0);
		rd("status_reg", io_claim_pkg::OFS_STATUS, 32'h10);
		wr(io_claim_pkg::OFS_DECODE_CTRL, 32'hFFFF_FFFF);
		rd("ctrl_rw", io_claim_pkg::OFS_DECODE_CTRL, 32'hFFEF_FFFF);
		wb(1'b1, io_claim_pkg::OFS_DECODE_CTRL, 4'h4, 32'h0, q);
		rd("ctrl_lane", io_claim_pkg::OFS_DECODE_CTRL, 32'hFF00_FFFF);
		wr(io_claim_pkg::OFS_SLOT_NINE, 32'hFFFF_FFFF);
		rd("nine_rw", io_claim_pkg::OFS_SLOT_NINE, 32'h000F_FFFF);
		wr(8'h90, 32'hFFFF_FFFF);
		rd("unmapped", 8'h90, 32'h0);
		wr(io_claim_pkg::OFS_MONITOR, 32'hFFFF_FFFF);
		rd("monitor_rw", io_claim_pkg::OFS_MONITOR, 32'h3);
		wr(io_claim_pkg::OFS_MONITOR, 32'h0);
		wr(io_claim_pkg::OFS_DECODE_CTRL, 32'h0);
		wr(io_claim_pkg::OFS_SLOT_NINE, 32'h0);
	endtask : regs_test

	task automatic serial_test(input logic b);
		logic [31:0] ctrl;
		logic [15:0] w;
		logic [1:0]  mon;
		mon = b ? 2'h2 : 2'h1;
		wr(io_claim_pkg::OFS_MONITOR, {30'h0, mon});
		for (int code = 0; code < 8; code++) begin
			w = WIN[code];
			ctrl = 32'({1'b1, code[2:0]}) << (b ? 28 : 24);
			wr(io_claim_pkg::OFS_DECODE_CTRL, ctrl);
			probe(1'b1, w, 1'b1, 1'b1, 1'b0);
			probe(1'b1, w | 16'h7, 1'b1, 1'b1, 1'b0);
			probe(1'b1, w + 16'h8, 1'b0, 1'b1, 1'b0);
			probe(1'b1, w - 16'h1, 1'b0, 1'b1, 1'b0);
			probe(1'b0, w, 1'b0, 1'b1, 1'b0);
		end
		wr(io_claim_pkg::OFS_MONITOR, {30'h0, ~mon});
		probe(1'b1, 16'h03E8, 1'b0, 1'b1, 1'b0);
		wr(io_claim_pkg::OFS_MONITOR, {30'h0, mon});
		probe(1'b1, 16'h03E8, 1'b1, 1'b1, 1'b0);
		wr(io_claim_pkg::OFS_DECODE_CTRL, ctrl & ~(32'h8800_0000));
		probe(1'b1, 16'h03E8, 1'b0, 1'b1, 1'b0);
	endtask : serial_test

	task automatic slot_ten_test;
		logic [2:0]  en;
		logic [15:0] a;
		logic        hit;
		for (int i = 0; i < 8; i++) begin
			en = i[2:0];
			wr(io_claim_pkg::OFS_DECODE_CTRL, {8'h0, en, 1'b0, 4'h9, 16'h0530});
			probe(1'b1, 16'h0539, en[0] & en[1], ~&en, 1'b0);
			probe(1'b1, 16'h0532, 1'b0, 1'b1, 1'b0);
		end
		for (int i = 0; i < 17; i++) begin
			a = (i == 16) ? 16'h8530 : 16'h0530 + 16'(i);
			hit = ((a ^ 16'h0530) & 16'hFFF6) == 16'h0;
			probe(1'b1, a, hit, ~hit, 1'b0);
		end
		i_host.hold(1'b1, 16'h0539);
		rd("status_hit", io_claim_pkg::OFS_STATUS, 32'h24);
		i_host.hold(1'b0, 16'h0539);
		probe(1'b0, 16'h0530, 1'b0, 1'b1, 1'b0);
		wr(io_claim_pkg::OFS_DECODE_CTRL, 32'h0);
	endtask : slot_ten_test

	task automatic slot_nine_test;
		logic [15:0] a;
		wr(io_claim_pkg::OFS_SLOT_NINE, 32'h0003_1234);
		rd("nine_reg", io_claim_pkg::OFS_SLOT_NINE, 32'h0003_1234);
		for (int i = 0; i < 17; i++) begin
			a = (i == 16) ? 16'h5234 : 16'h1230 + 16'(i);
			probe(1'b1, a, 1'b0, 1'b1, ((a ^ 16'h1234) & 16'hFFFC) == 0);
		end
		probe(1'b0, 16'h1234, 1'b0, 1'b1, 1'b0);
	endtask : slot_nine_test

	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// Whole run is a few hundred cycles; this leaves wide margin
	initial begin
		#200000;
		n_mismatch++;
		final_report;
	end

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		sel = 4'h0;
		dat_w = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		regs_test;
		serial_test(1'b1);
		serial_test(1'b0);
		slot_ten_test;
		slot_nine_test;
		final_report;
	end
endmodule : io_range_claim_decode_test
